// ---- design/rtc_pkg.sv ----
// constants, offsets and state codes for the seconds counter
// assumes the seconds counter and the bench import it; tick_sync does not
package rtc_pkg;

    // ********************************************************
    // bus widths and window decode
    // ********************************************************
    localparam int          ADDR_W    = 20;
    localparam int          DATA_W    = 32;
    localparam int          OFF_W     = 12;
    localparam logic [7:0]  WIN_PAGE  = 8'h17;   // window at 0x17000 in the chip select

    // ********************************************************
    // word offsets inside the window
    // ********************************************************
    localparam logic [11:0] OFF_COUNT = 12'h000; // read count, write preset
    localparam logic [11:0] OFF_MATCH = 12'h004; // alarm second
    localparam logic [11:0] OFF_MASK  = 12'h008; // bit 0 lets the interrupt out
    localparam logic [11:0] OFF_STAT  = 12'h00c; // read flags, write 1 clears alarm

    // ********************************************************
    // values after reset
    // ********************************************************
    localparam logic [31:0] COUNT_RST = 32'h0000_0000;
    localparam logic [31:0] MATCH_RST = 32'h0000_0000;
    localparam logic        PASS_RST  = 1'b0;    // interrupt masked out of reset
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

    // ********************************************************
    // control states
    // ********************************************************
    typedef enum logic [1:0] {
        ST_LOAD = 2'b01,
        ST_RUN  = 2'b10
    } rtc_state_t;

endpackage

// ---- design/seconds_counter_rtc.sv ----
// seconds counter with alarm, mask and time-of-year mirror
// assumes a bus synchronous to clk_i and a time-of-year clock on the same clock
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - once running, counter steps by one on each synchronised second tick that meets no preset
// - count readable any cycle, reading never changes it
// - alarm flag sets when the count steps onto the programmed match second
// - mask bit written by software gates the alarm onto the interrupt output
// - only accesses to page 0x17000 of the selected chip select are decoded
// - after reset the count waits for and takes the time-of-year value
// - every write into the window is forwarded to the time-of-year clock
module seconds_counter_rtc (
    input  wire logic                        clk_i,
    input  wire logic                        nrst_i,
    input  wire logic                        en_i,
    input  wire logic                        tick_i,
    input  wire logic                        alt_map_i,
    input  wire logic                        cs_legacy_i,
    input  wire logic                        cs_alt_i,
    input  wire logic [rtc_pkg::ADDR_W-1:0]  addr_i,
    input  wire logic                        we_i,
    input  wire logic                        re_i,
    input  wire logic [rtc_pkg::DATA_W-1:0]  wdata_i,
    input  wire logic                        toy_valid_i,
    input  wire logic [rtc_pkg::DATA_W-1:0]  toy_value_i,
    output logic      [rtc_pkg::DATA_W-1:0]  rdata_o,
    output logic                             rvalid_o,
    output logic                             irq_o,
    output logic                             running_o,
    output logic                             toy_wr_o,
    output logic      [rtc_pkg::OFF_W-1:0]   toy_waddr_o,
    output logic      [rtc_pkg::DATA_W-1:0]  toy_wdata_o
);
    import rtc_pkg::*;

    // ********************************************************
    // declarations
    // ********************************************************
    rtc_state_t        state;
    rtc_state_t        next_state;
    logic [DATA_W-1:0] count;
    logic [DATA_W-1:0] next_count;
    logic [DATA_W-1:0] match;
    logic [DATA_W-1:0] next_match;
    logic              pass;
    logic              next_pass;
    logic              raw;
    logic              next_raw;
    logic              next_irq;
    logic [DATA_W-1:0] next_rdata;
    logic              next_rvalid;
    logic              next_toy_wr;
    logic [OFF_W-1:0]  next_toy_waddr;
    logic [DATA_W-1:0] next_toy_wdata;
    logic              tick;
    logic              sel;
    logic              hit;
    logic [OFF_W-1:0]  off;
    logic              wr;
    logic              rd;
    logic              wr_count;
    logic              wr_clear;
    logic              alarm;
    logic [DATA_W-1:0] count_inc;

    // ********************************************************
    // second tick from the foreign oscillator
    // ********************************************************
    tick_sync u_tick (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .en_i   (en_i),
        .tick_i (tick_i),
        .tick_o (tick)
    );

    // ********************************************************
    // window decode
    // ********************************************************
    assign sel      = alt_map_i ? cs_alt_i : cs_legacy_i;
    assign hit      = sel && (addr_i[ADDR_W-1:OFF_W] == WIN_PAGE);
    assign off      = addr_i[OFF_W-1:0];
    assign wr       = hit & we_i;
    assign rd       = hit & re_i & ~we_i;   // write wins if both strobes are up
    assign wr_count = wr && (off == OFF_COUNT) && (state == ST_RUN);
    assign wr_clear = wr && (off == OFF_STAT) && wdata_i[0];
    assign count_inc = count + 32'h0000_0001;
    // a preset in the same cycle as a tick replaces the step, no alarm from it
    assign alarm    = (state == ST_RUN) && tick && !wr_count && (count_inc == match);

    // ********************************************************
    // next values of all control state
    // ********************************************************
    always_comb begin
        next_state = state;
        next_count = count;
        next_match = match;
        next_pass  = pass;
        case (state)
            ST_LOAD: begin
                // counting held off until the time-of-year value arrives
                if (toy_valid_i) begin
                    next_count = toy_value_i;
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (wr_count) begin
                    next_count = wdata_i;
                end else if (tick) begin
                    next_count = count_inc;
                end
            end
            default: begin
                next_state = ST_LOAD;
            end
        endcase
        if (wr && (off == OFF_MATCH)) begin
            next_match = wdata_i;
        end
        if (wr && (off == OFF_MASK)) begin
            next_pass = wdata_i[0];
        end
        // set wins over a clear in the same cycle
        next_raw = alarm | (raw & ~wr_clear);
        next_irq = next_raw & next_pass;
    end

    // read data and time-of-year mirror, one cycle after the strobe
    always_comb begin
        next_rdata = DATA_ZERO;
        if (rd) begin
            case (off)
                OFF_COUNT: next_rdata = count;
                OFF_MATCH: next_rdata = match;
                OFF_MASK:  next_rdata = {31'h0000_0000, pass};
                OFF_STAT:  next_rdata = {30'h0000_0000, raw & pass, raw};
                default:   next_rdata = DATA_ZERO;
            endcase
        end
        next_rvalid    = rd;
        next_toy_wr    = wr;
        next_toy_waddr = off;
        next_toy_wdata = wdata_i;
    end

    // ********************************************************
    // registers, all frozen while en_i is low
    // ********************************************************
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state       <= ST_LOAD;
            count       <= COUNT_RST;
            match       <= MATCH_RST;
            pass        <= PASS_RST;
            raw         <= 1'b0;
            irq_o       <= 1'b0;
            rdata_o     <= DATA_ZERO;
            rvalid_o    <= 1'b0;
            toy_wr_o    <= 1'b0;
            toy_waddr_o <= 12'h000;
            toy_wdata_o <= DATA_ZERO;
        end else if (en_i) begin
            state       <= next_state;
            count       <= next_count;
            match       <= next_match;
            pass        <= next_pass;
            raw         <= next_raw;
            irq_o       <= next_irq;
            rdata_o     <= next_rdata;
            rvalid_o    <= next_rvalid;
            toy_wr_o    <= next_toy_wr;
            toy_waddr_o <= next_toy_waddr;
            toy_wdata_o <= next_toy_wdata;
        end
    end

    // running flag is the state flop itself
    assign running_o = state[1];

    // ********************************************************
    // assertions
    // ********************************************************
    property p_count_step;
        @(posedge clk_i) disable iff (!nrst_i)
        (en_i && state == ST_RUN && tick && !wr_count) |=> (count == $past(count) + 32'h1);
    endproperty
    a_count_step: assert property (p_count_step) else $error("count did not step");

    property p_read_value;
        @(posedge clk_i) disable iff (!nrst_i)
        (en_i && rd && off == OFF_COUNT) |=> (rvalid_o && rdata_o == $past(count));
    endproperty
    a_read_value: assert property (p_read_value) else $error("bad count read");

    property p_read_quiet;
        @(posedge clk_i) disable iff (!nrst_i)
        (en_i && rd && state == ST_RUN && !tick) |=> $stable(count);
    endproperty
    a_read_quiet: assert property (p_read_quiet) else $error("read moved count");

    property p_alarm_set;
        @(posedge clk_i) disable iff (!nrst_i)
        (en_i && state == ST_RUN && tick && !wr_count && count + 32'h1 == match) |=> raw;
    endproperty
    a_alarm_set: assert property (p_alarm_set) else $error("alarm missed");

    property p_mask_gate;
        @(posedge clk_i) disable iff (!nrst_i)
        irq_o == (raw & pass);
    endproperty
    a_mask_gate: assert property (p_mask_gate) else $error("mask not applied");

    property p_decode;
        @(posedge clk_i) disable iff (!nrst_i)
        (en_i && we_i && !hit) |=> ($stable(match) && $stable(pass) && !toy_wr_o);
    endproperty
    a_decode: assert property (p_decode) else $error("write outside window took");

    property p_load;
        @(posedge clk_i) disable iff (!nrst_i)
        (en_i && state == ST_LOAD && toy_valid_i) |=>
            (count == $past(toy_value_i) && running_o);
    endproperty
    a_load: assert property (p_load) else $error("power-up load failed");

    property p_forward;
        @(posedge clk_i) disable iff (!nrst_i)
        (en_i && wr) |=> (toy_wr_o && toy_wdata_o == $past(wdata_i) && toy_waddr_o == $past(off));
    endproperty
    a_forward: assert property (p_forward) else $error("write not mirrored");

    property p_hold;
        @(posedge clk_i) disable iff (!nrst_i)
        (raw && !(en_i && wr_clear)) |=> raw;
    endproperty
    a_hold: assert property (p_hold) else $error("alarm dropped early");

endmodule
`default_nettype wire

// ---- design/tick_sync.sv ----
// second-tick synchroniser with rising edge detect
// assumes tick_i comes from a foreign oscillator, wider than two clk_i periods
`timescale 1ns/1ps
`default_nettype none

module tick_sync (
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic en_i,
    input  wire logic tick_i,
    output logic      tick_o
);

    logic meta;
    logic stable;
    logic prev;
    logic next_meta;
    logic next_stable;
    logic next_prev;

    // ********************************************************
    // two-flop crossing, edge taken only on the second stage
    // ********************************************************
    always_comb begin
        next_meta   = tick_i;
        next_stable = meta;   // meta feeds nothing else
        next_prev   = stable;
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta   <= 1'b0;
            stable <= 1'b0;
            prev   <= 1'b0;
        end else if (en_i) begin
            meta   <= next_meta;
            stable <= next_stable;
            prev   <= next_prev;
        end
    end

    // one pulse per rising edge of the second tick
    assign tick_o = stable & ~prev;

endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the seconds counter with a time-of-year model
// assumes the bus is synchronous to clk_i and inputs move 1 ns after edges
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import rtc_pkg::*;
    // ********
    // stimulus and wiring
    // ********
    localparam logic [31:0] TOY_START = 32'h0000_1000;
    typedef struct packed {
        logic        w;
        logic [19:0] a;
        logic [31:0] d;
    } row_t;
    logic        clk_i = 1'b0, nrst_i = 1'b0, en_i = 1'b1, tick_i = 1'b0;
    logic        alt_map_i = 1'b0, bad_cs = 1'b0, we_i = 1'b0, re_i = 1'b0;
    logic [19:0] addr_i = 20'h0_0000;
    logic [31:0] wdata_i = 32'h0000_0000;
    logic        cs_legacy_i, cs_alt_i, toy_valid_i, rvalid_o, irq_o, running_o, toy_wr_o;
    logic [31:0] toy_value_i, rdata_o, toy_wdata_o;
    logic [11:0] toy_waddr_o;
    int          mismatches = 0;
    int          checks = 0;
    row_t        rows [8] = '{
        '{1'b1, 20'h17004, 32'h5}, '{1'b0, 20'h17004, 32'h5},
        '{1'b1, 20'h17008, 32'h1}, '{1'b0, 20'h17008, 32'h1},
        '{1'b0, 20'h1700c, 32'h0}, '{1'b0, 20'h17010, 32'h0},
        '{1'b1, 20'h17000, 32'h3}, '{1'b0, 20'h17000, 32'h3}};

    // bad_cs flips both selects so the wrong one is active
    assign cs_legacy_i = !alt_map_i ^ bad_cs;
    assign cs_alt_i    = alt_map_i ^ bad_cs;

    always #2 clk_i = !clk_i;

    seconds_counter_rtc dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .en_i(en_i), .tick_i(tick_i),
        .alt_map_i(alt_map_i), .cs_legacy_i(cs_legacy_i), .cs_alt_i(cs_alt_i),
        .addr_i(addr_i), .we_i(we_i), .re_i(re_i), .wdata_i(wdata_i),
        .toy_valid_i(toy_valid_i), .toy_value_i(toy_value_i), .rdata_o(rdata_o),
        .rvalid_o(rvalid_o), .irq_o(irq_o), .running_o(running_o), .toy_wr_o(toy_wr_o),
        .toy_waddr_o(toy_waddr_o), .toy_wdata_o(toy_wdata_o));

    toy_model #(.START(TOY_START)) toy_u (.clk_i(clk_i), .nrst_i(nrst_i), .wr_i(toy_wr_o),
        .waddr_i(toy_waddr_o), .wdata_i(toy_wdata_o), .valid_o(toy_valid_i),
        .value_o(toy_value_i));

    // ********
    // helpers
    // ********
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk32({31'h0, got}, {31'h0, exp});
    endtask

    // every step lands 1 ns past an edge so the design sees settled inputs
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // one bus access; ans says whether the window should take it
    task automatic acc(input logic w, input logic [19:0] a, input logic [31:0] d,
                       input logic ans);
        addr_i  = a;
        wdata_i = d;
        we_i    = w;
        re_i    = !w;
        cyc(1);
        we_i = 1'b0;
        re_i = 1'b0;
        if (w) begin
            chk1(toy_wr_o, ans);
            if (ans) chk32({toy_waddr_o, toy_wdata_o[19:0]}, {a[11:0], d[19:0]});
        end else begin
            chk1(rvalid_o, ans);
            if (ans) chk32(rdata_o, d);
        end
        // idle edge so a following call never re-raises a strobe in this step
        cyc(1);
    endtask

    // tick held 4 cycles each level, longer than the synchroniser needs
    task automatic tick();
        tick_i = 1'b1;
        cyc(4);
        tick_i = 1'b0;
        cyc(4);
    endtask

    task automatic done_test(input string s);
        $display("test %s done", s);
    endtask

    // hang guard
    initial begin
        repeat (5000) @(posedge clk_i);
        mismatches++;
        $display("ERROR %0t run did not finish", $time);
        report_and_stop();
    end

    // ********
    // main sequence
    // ********
    initial begin
        cyc(5);
        nrst_i = 1'b1;
        for (int i = 0; i < 20 && running_o !== 1'b1; i++) cyc(1);
        chk1(running_o, 1'b1);
        if (running_o !== 1'b1) report_and_stop();
        acc(1'b0, 20'h17000, TOY_START, 1'b1);
        done_test("load");
        foreach (rows[i]) acc(rows[i].w, rows[i].a, rows[i].d, 1'b1);
        cyc(1);
        chk32(toy_value_i, 32'h3);
        done_test("table");
        tick();
        acc(1'b0, 20'h17000, 32'h4, 1'b1);
        chk1(irq_o, 1'b0);
        tick();
        chk1(irq_o, 1'b1);
        acc(1'b0, 20'h17000, 32'h5, 1'b1);
        acc(1'b0, 20'h17000, 32'h5, 1'b1);
        cyc(10);
        chk1(irq_o, 1'b1);
        acc(1'b1, 20'h17008, 32'h0, 1'b1);
        cyc(1);
        chk1(irq_o, 1'b0);
        acc(1'b0, 20'h1700c, 32'h1, 1'b1);
        acc(1'b1, 20'h17008, 32'h1, 1'b1);
        cyc(1);
        chk1(irq_o, 1'b1);
        acc(1'b1, 20'h1700c, 32'h1, 1'b1);
        cyc(1);
        chk1(irq_o, 1'b0);
        done_test("alarm");
        bad_cs = 1'b1;
        acc(1'b0, 20'h17000, 32'h5, 1'b0);
        bad_cs = 1'b0;
        acc(1'b0, 20'h16000, 32'h0, 1'b0);
        acc(1'b1, 20'h18004, 32'h9, 1'b0);
        alt_map_i = 1'b1;
        acc(1'b0, 20'h17004, 32'h5, 1'b1);
        done_test("decode");
        // clock enable low: no access taken and the tick is lost
        en_i = 1'b0;
        acc(1'b0, 20'h17000, 32'h5, 1'b0);
        tick();
        en_i = 1'b1;
        acc(1'b0, 20'h17000, 32'h5, 1'b1);
        done_test("enable");
        // mid-run reset: back to power-up values, then a fresh load
        nrst_i = 1'b0;
        cyc(2);
        chk1(running_o, 1'b0);
        chk1(irq_o, 1'b0);
        nrst_i = 1'b1;
        cyc(1);
        chk1(running_o, 1'b0);
        for (int i = 0; i < 20 && running_o !== 1'b1; i++) cyc(1);
        chk1(running_o, 1'b1);
        acc(1'b0, 20'h17000, TOY_START, 1'b1);
        acc(1'b0, 20'h17004, MATCH_RST, 1'b1);
        done_test("reset");
        report_and_stop();
    end
endmodule

`default_nettype wire

// ---- tb/toy_model.sv ----
// time-of-year clock model facing the seconds counter
// assumes the counter mirrors window writes as one-cycle pulses on clk_i
`timescale 1ns/1ps
`default_nettype none

module toy_model #(
    parameter logic [31:0] START = 32'h0000_1000,
    parameter int          DLY   = 3
) (
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic        wr_i,
    input  wire logic [11:0] waddr_i,
    input  wire logic [31:0] wdata_i,
    output logic             valid_o,
    output logic      [31:0] value_o
);
    // ********
    // board clock state
    // ********
    int          wait_cnt;
    logic [31:0] stored;

    // slow to come up after power-on, then offers its value for good
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wait_cnt <= 0;
            stored   <= START;
        end else begin
            if (wait_cnt < DLY) begin
                wait_cnt <= wait_cnt + 1;
            end
            if (wr_i && waddr_i == 12'h000) begin
                stored <= wdata_i; // count writes keep both clocks equal
            end
        end
    end

    assign valid_o = (wait_cnt >= DLY);
    assign value_o = stored;
endmodule

`default_nettype wire
